// ==== core/xbi_map.svh ====
// Constants for the external bus pin interface
// Contract
// - Address lines are outputs only, driven when pin alternate and interface enabled.
// - Enabled address lines read zero while running from internal program memory.
// - Each address line alternate function is enabled on its own.
// - Enabled data lines are bidirectional, carrying read and write data.
// - Each data line alternate function is enabled on its own.
// - Data lines float except during an external write.
// - Data bus width selectable, 8 bits low lanes or 16 bits.
// - Read strobe asserted during external reads, deasserted otherwise.
// - Ports A to K without I, eight bits each, port H four bits.
// - Write strobe asserted during external writes.
// - Six chip selects with selectable active polarity.
// - Wait input stalls the ongoing bus transaction until released.
`ifndef XBI_MAP_SVH
`define XBI_MAP_SVH
`define XBI_ADDR_W   24
`define XBI_DATA_W   16
`define XBI_NUM_CS   6
`define XBI_PORT_W   8
`define XBI_PORTH_W  4
`define XBI_NUM_PORT 10
`endif

// ==== core/xbi_pkg.sv ====
// Types for the external bus pin interface
`default_nettype none
`include "xbi_map.svh"
package xbi_pkg;
  typedef enum logic [2:0] {
    XBI_IDLE  = 3'b001,
    XBI_READ  = 3'b010,
    XBI_WRITE = 3'b100
  } xbi_state_t;

  // One bus request from the CPU side
  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic [`XBI_ADDR_W-1:0]   addr;
    logic [`XBI_DATA_W-1:0]   wdata;
    logic [`XBI_NUM_CS-1:0]   cs;
  } xbi_req_t;
endpackage : xbi_pkg
`default_nettype wire

// ==== core/xbi_pins.sv ====
// External bus pin interface: bus sequencing and pin muxing onto GPIO
`default_nettype none
`include "xbi_map.svh"
module xbi_pins
  import xbi_pkg::*;
#(
  parameter int ADDR_W = `XBI_ADDR_W,
  parameter int DATA_W = `XBI_DATA_W,
  parameter int NUM_CS = `XBI_NUM_CS
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire xbi_req_t            i_req,
  input  wire logic                i_int_exec,
  input  wire logic                i_if_en,
  input  wire logic                i_bus16,
  input  wire logic [ADDR_W-1:0]   i_addr_alt_en,
  input  wire logic [DATA_W-1:0]   i_data_alt_en,
  input  wire logic [NUM_CS-1:0]   i_cs_pol,
  input  wire logic                i_wait,
  input  wire logic [ADDR_W-1:0]   i_gpio_addr_out,
  input  wire logic [ADDR_W-1:0]   i_gpio_addr_oe_n,
  input  wire logic [DATA_W-1:0]   i_gpio_data_out,
  input  wire logic [DATA_W-1:0]   i_gpio_data_oe_n,
  input  wire logic [DATA_W-1:0]   i_data_pin,
  output logic [ADDR_W-1:0]        o_addr_pin,
  output logic [ADDR_W-1:0]        o_addr_oe_n,
  output logic [DATA_W-1:0]        o_data_pin,
  output logic [DATA_W-1:0]        o_data_oe_n,
  output logic                     o_rd_n,
  output logic                     o_wr_n,
  output logic [NUM_CS-1:0]        o_chip_sel,
  output logic                     o_upper_byte_lane_en,
  output logic                     o_lower_byte_lane_en,
  output logic                     o_busy,
  output logic                     o_done,
  output logic [DATA_W-1:0]        o_rdata
);

  xbi_state_t          state_r;
  xbi_state_t          state_nxt;
  xbi_req_t            req_r;
  logic                active;
  logic [ADDR_W-1:0]   addr_val;
  logic [ADDR_W-1:0]   addr_own;
  logic [DATA_W-1:0]   data_own;
  logic [DATA_W-1:0]   lane_mask;

  // Ports A to K without I, H has four pins; bus pins borrow from these
  localparam int PORT_PINS = (`XBI_NUM_PORT - 1) * `XBI_PORT_W + `XBI_PORTH_W;

  // Bus cycle sequencing; one request at a time, wait holds the phase
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      XBI_IDLE: begin
        if (i_if_en && i_req.rd) begin
          state_nxt = XBI_READ;
        end else if (i_if_en && i_req.wr) begin
          state_nxt = XBI_WRITE;
        end
      end
      XBI_READ, XBI_WRITE: begin
        if (!i_wait) begin
          state_nxt = XBI_IDLE;
        end
      end
    endcase
  end

  // State register, back to idle on reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r <= XBI_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch the request so pins stay stable through wait stalls
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_r <= '0;
    end else if (state_r == XBI_IDLE) begin
      req_r <= i_req;
    end
  end

  // Next-state view, so strobes and pins switch on the taking edge
  assign active = (state_nxt != XBI_IDLE);

  // Lanes used by the bus: low byte only in 8-bit mode
  assign lane_mask = i_bus16 ? {DATA_W{1'b1}} : {{(DATA_W/2){1'b0}}, {(DATA_W/2){1'b1}}};

  // Per-pin ownership: each alternate enable stands alone
  assign addr_own = i_if_en ? i_addr_alt_en : '0;
  assign data_own = i_if_en ? (i_data_alt_en & lane_mask) : '0;

  // Address reads zero during internal execution
  assign addr_val = i_int_exec ? '0 : ((state_r == XBI_IDLE) ? i_req.addr : req_r.addr);

  // Address pins: output only when owned, else GPIO
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_addr_pin  <= '0;
      o_addr_oe_n <= {ADDR_W{1'b1}};
    end else begin
      o_addr_pin  <= (addr_own & addr_val) | (~addr_own & i_gpio_addr_out);
      // Owned pins always drive; unowned ones keep the port's own enable
      o_addr_oe_n <= ~addr_own & i_gpio_addr_oe_n;
    end
  end

  // Data pins: driven by the bus only in a write, floating otherwise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_data_pin  <= '0;
      o_data_oe_n <= {DATA_W{1'b1}};
    end else begin
      o_data_pin  <= (data_own & (active ? ((state_r == XBI_IDLE) ? i_req.wdata : req_r.wdata) : '0))
                     | (~data_own & i_gpio_data_out);
      o_data_oe_n <= (data_own & ~{DATA_W{state_nxt == XBI_WRITE}})
                     | (~data_own & i_gpio_data_oe_n);
    end
  end

  // Strobes, chip selects and byte lane enables
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_n               <= 1'b1;
      o_wr_n               <= 1'b1;
      o_chip_sel           <= '0;
      o_upper_byte_lane_en <= 1'b0;
      o_lower_byte_lane_en <= 1'b0;
    end else begin
      o_rd_n               <= ~(state_nxt == XBI_READ);
      o_wr_n               <= ~(state_nxt == XBI_WRITE);
      // Polarity bit set means active high
      o_chip_sel           <= active ? ~(((state_r == XBI_IDLE) ? i_req.cs : req_r.cs) ^ i_cs_pol)
                                     : ~i_cs_pol;
      o_upper_byte_lane_en <= active && i_bus16;
      o_lower_byte_lane_en <= active;
    end
  end

  // Status and captured read data
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_busy <= active;
      o_done <= (state_r != XBI_IDLE) && !i_wait;
      if (state_r == XBI_READ && !i_wait) begin
        o_rdata <= i_data_pin & lane_mask;
      end
    end
  end

  // Assertions
  chk_rd_strobe_state: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_r == XBI_READ) |-> !o_rd_n) else $error("read strobe not asserted in read");
  chk_wr_strobe_state: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_r == XBI_WRITE) |-> !o_wr_n) else $error("write strobe not asserted in write");
  chk_data_float_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_wr_n |-> ((~o_data_oe_n & $past(data_own)) == '0))
    else $error("data driven outside write");
  chk_addr_zero_int: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($past(i_int_exec) && $past(i_if_en)) |-> ((o_addr_pin & $past(i_addr_alt_en)) == '0))
    else $error("address not zero during internal execution");
  chk_addr_gpio_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_if_en))
      |-> (o_addr_pin == $past(i_gpio_addr_out) && o_addr_oe_n == $past(i_gpio_addr_oe_n)))
    else $error("address pins taken while interface off");
  chk_addr_out_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && $past(i_if_en)) |-> ((~o_addr_oe_n & $past(i_addr_alt_en)) == $past(i_addr_alt_en)))
    else $error("owned address pin not driven");
  sequence s_wait_hold;
    (state_r != XBI_IDLE) && i_wait;
  endsequence
  chk_wait_stall: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_wait_hold |=> (state_r == $past(state_r)) && !o_done) else $error("wait did not stall bus");
  chk_upper_lane_8: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !$past(i_bus16) |-> !o_upper_byte_lane_en) else $error("upper lane used in 8-bit mode");
  chk_cs_idle_pol: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && $past(state_nxt) == XBI_IDLE) |-> (o_chip_sel == ~$past(i_cs_pol)))
    else $error("chip select active when idle");

  // Pin ownership, byte lanes and the end of each cycle
  chk_addr_pin_own: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && $past(i_if_en)) |-> (o_addr_oe_n == (~$past(i_addr_alt_en) & $past(i_gpio_addr_oe_n))))
    else $error("address pin enable not per pin");
  chk_data_gpio_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_if_en))
      |-> (o_data_oe_n == $past(i_gpio_data_oe_n) && o_data_pin == $past(i_gpio_data_out)))
    else $error("data pins taken while interface off");
  chk_upper_data_8: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_bus16))
      |-> (o_data_oe_n[DATA_W-1:DATA_W/2] == $past(i_gpio_data_oe_n[DATA_W-1:DATA_W/2])))
    else $error("upper data lanes used in 8-bit mode");
  chk_wr_drive_data: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_wr_n |-> ((o_data_oe_n & $past(data_own)) == '0))
    else $error("owned data pin not driven in write");
  chk_rdata_lane_8: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($past(state_r) == XBI_READ && !$past(i_wait) && !$past(i_bus16)) |-> (o_rdata[DATA_W-1:DATA_W/2] == '0))
    else $error("upper read byte kept in 8-bit mode");
  chk_lower_lane_busy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_lower_byte_lane_en == o_busy)
    else $error("lower lane enable not matching bus cycle");
  chk_strobe_busy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_busy == (o_rd_n ^ o_wr_n))
    else $error("strobes not exactly one per bus cycle");
  sequence s_cycle_end;
    (state_r != XBI_IDLE) && !i_wait;
  endsequence
  chk_cycle_end: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_cycle_end |=> o_done && o_rd_n && o_wr_n && !o_busy)
    else $error("bus cycle did not end after wait released");
  chk_done_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_done |=> !o_done)
    else $error("done held longer than one cycle");

endmodule : xbi_pins
`default_nettype wire

// ==== verification/xbi_mem_model.sv ====
// Behavioural external memory with wait states
`default_nettype none
module xbi_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_slow,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_pin,
  input  wire logic [15:0] i_oe_n,
  output logic      [15:0] o_wire,
  output logic             o_wait
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  cnt_r;
  logic [15:0] last_r = 16'h0000;
  // Cycles since strobe went low
  always @(posedge i_sys_clk) begin
    cnt_r  <= (i_rd_n & i_wr_n) ? 3'h0 : cnt_r + 3'h1;
    last_r <= o_wire;
  end
  assign o_wait = i_slow & ~(i_rd_n & i_wr_n) & (cnt_r < 3'h2);
  // Undriven lines carry read data while the read strobe is low and toggle otherwise, so a float never looks like data
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      o_wire[b] = ~i_oe_n[b] ? i_pin[b] : (~i_rd_n ? i_addr[b] ^ i_addr[b+8] : ~last_r[b]);
    end
  end
endmodule : xbi_mem_model
`default_nettype wire

// ==== verification/xbi_pins_test.sv ====
// Self-checking bench for the external bus pin interface
`default_nettype none
module xbi_pins_test;
  import xbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, int_exec = 0, if_en = 1, bus16 = 1, slow = 0;
  logic        rd_n, wr_n, ub, lb, busy, done, wt;
  xbi_req_t    req = '0;
  logic [23:0] aen = '1, ga = '0, gao = '1, a_pin, a_oe_n;
  logic [15:0] den = '1, gd = '0, gdo = '1, wire_d, d_pin, d_oe_n, rdata, last_rd = 16'h0000;
  logic [5:0]  pol = '0, sel;
  logic [31:0] rnd = 32'h0000_0016;
  logic [15:0] exp_q[$];
  int          mismatches = 0, check_count = 0, cycles = 0;
  xbi_pins dut (.i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_int_exec(int_exec), .i_if_en(if_en),
    .i_bus16(bus16), .i_addr_alt_en(aen), .i_data_alt_en(den), .i_cs_pol(pol), .i_wait(wt),
    .i_gpio_addr_out(ga), .i_gpio_addr_oe_n(gao), .i_gpio_data_out(gd), .i_gpio_data_oe_n(gdo),
    .i_data_pin(wire_d), .o_addr_pin(a_pin), .o_addr_oe_n(a_oe_n), .o_data_pin(d_pin),
    .o_data_oe_n(d_oe_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_chip_sel(sel), .o_upper_byte_lane_en(ub),
    .o_lower_byte_lane_en(lb), .o_busy(busy), .o_done(done), .o_rdata(rdata));
  xbi_mem_model mem (.i_sys_clk(clk), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_slow(slow), .i_addr(a_pin),
    .i_pin(d_pin), .i_oe_n(d_oe_n), .o_wire(wire_d), .o_wait(wt));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Hang guard, far above the roughly 56 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  // Watcher takes the oldest note at each completion
  always @(negedge clk) begin
    if (done === 1'b1) check(rdata, exp_q.pop_front());
  end
  // One bus cycle with random pins and enables
  task automatic xfer(input logic wr);
    logic [23:0] ea;
    logic [15:0] own, ed, m;
    int n;
    rnd = lfsr(rnd); req.addr = rnd[23:0]; pol = rnd[29:24];
    rnd = lfsr(rnd); req.wdata = rnd[15:0]; den = rnd[31:16]; req.cs = rnd[5:0];
    rnd = lfsr(rnd); aen = rnd[23:0]; gd = rnd[15:0]; gdo = rnd[31:16];
    rnd = lfsr(rnd); ga = rnd[23:0]; gao = rnd[31:8];
    ea = (aen & (int_exec ? 24'h00_0000 : req.addr)) | (~aen & ga);
    own = den & (bus16 ? 16'hFFFF : 16'h00FF);
    ed = (own & req.wdata) | (~own & gd);
    m = ea[15:0] ^ ea[23:8];
    m = ((m & (own | gdo)) | (gd & ~(own | gdo))) & (bus16 ? 16'hFFFF : 16'h00FF);
    if (!wr) last_rd = m;
    exp_q.push_back(last_rd);
    req.rd = !wr;
    req.wr = wr;
    @(posedge clk);
    @(negedge clk);
    req.rd = 0;
    req.wr = 0;
    check(a_pin, ea);
    check(a_oe_n, ~aen & gao);
    check(d_oe_n, wr ? ~own & gdo : own | gdo);
    if (wr) check(d_pin, ed);
    check({rd_n, wr_n, sel, ub, lb, busy}, {wr, !wr, ~(req.cs ^ pol), bus16, 2'b11});
    for (n = 0; n < 10 && done !== 1'b1; n++) @(negedge clk);
    check(n, slow ? 3 : 1);
    check({rd_n, wr_n, busy, d_oe_n}, {3'b110, own | gdo});
  endtask : xfer
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 16; i++) begin
      bus16 = i[1]; slow = i[2]; int_exec = i[3] & i[2];
      xfer(i[0]);
      $display("test %0d finished", i);
    end
    // Disabled interface takes no read and leaves the address pin enables to the port logic
    if_en = 0;
    req.rd = 1;
    repeat (3) @(negedge clk);
    check({busy, rd_n, a_oe_n}, {2'b01, gao});
    $display("test refusal finished");
    results();
  end
endmodule : xbi_pins_test
`default_nettype wire
